/* File: bench/cpu_local_bus_strobes_ready_irq_bench.sv */
// Self-checking bench for the local bus unit
`timescale 1ns/1ps
`include "local_bus_regs.svh"
module cpu_local_bus_strobes_ready_irq_bench;
  import local_bus_pkg::*;

  localparam logic [7:0] IRQ_TYPE = 8'h21;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic instr_last_i = 1'b0, irq_i = 1'b0, ready, mon_on = 1'b0, irq_on = 1'b0;
  logic cur_mem, cur_byte, cur_a0, cur_sp, inta_d = 1'b1;
  logic [1:0]  cur_seg;
  logic [15:0] cur_wd, mem_data, ad_in;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, r;
  logic [3:0]  wait_n = 4'h0;
  logic        ack_o;
  bus_pins_t   bus_o;
  int n_mismatch = 0, tests_run = 0, rd_low, wr_low, ale_cnt, inta_falls = 0, i;
  integer seed;

  always #20 clk_i = ~clk_i;
  assign ad_in = bus_o.muxed_addr_data_oe ? bus_o.muxed_addr_data : mem_data;

  local_bus_unit dut_u (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .sel_i(4'hf), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .instr_last_i(instr_last_i), .maskable_irq_i(irq_i), .ready_i(ready),
    .muxed_addr_data_i(ad_in), .bus_o(bus_o));
  local_bus_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_o), .wait_n_i(wait_n),
    .irq_type_i(IRQ_TYPE), .ready_o(ready), .data_o(mem_data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [15:0] mem_word(input logic [19:0] a);
    return a[15:0] ^ 16'h5a5a;
  endfunction

  // Ready comes two strobe clocks into t3, then two more per wait state
  function automatic int exp_rd_low(input logic [3:0] w);
    return (w <= 4'h2) ? 3 : 3 + 2 * ((int'(w) - 1) / 2);
  endfunction

  // Classic single cycle; no fixed latency assumed, only a bounded wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_mismatch++;
      print_verdict();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic poll(input int bit_no, input logic want);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, `REG_STATUS, 32'h0, r);
      n++;
    end
    while (r[bit_no] !== want && n < 200);
    if (n >= 200)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  task automatic run_cycle(input logic [2:0] k, input logic b, input logic [1:0] s,
                           input logic [19:0] a, input logic [15:0] wd, input logic sp);
    cur_mem = (k < 3'd2);
    cur_byte = b;
    cur_a0 = a[0];
    cur_seg = s;
    cur_sp = sp;
    cur_wd = wd;
    wb(1'b1, `REG_CTRL, {29'h0, sp, 2'b00}, r);
    wb(1'b1, `REG_ADDR, {12'h000, a}, r);
    wb(1'b1, `REG_WDATA, {16'h0000, wd}, r);
    rd_low = 0;
    wr_low = 0;
    mon_on = 1'b1;
    wb(1'b1, `REG_CMD, {26'h0, s, b, k}, r);
    poll(0, 1'b0);
    mon_on = 1'b0;
    check("strobes_idle", 32'h7, {bus_o.rd_n, bus_o.wr_n, bus_o.inta_n});
    if (!k[0])
    begin
      check("rd_count_ok", 32'h1, rd_low >= 3 && rd_low % 2 == 1);
      check("rd_waits", exp_rd_low(wait_n), rd_low);
      check("wr_quiet", 32'h0, wr_low);
      if (!b)
      begin
        wb(1'b0, `REG_RDATA, 32'h0, r);
        check("rdata", {16'h0000, mem_word(a)}, r);
      end
    end
    else
    begin
      check("rd_quiet", 32'h0, rd_low);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    if (!bus_o.inta_n && inta_d)
    begin
      inta_falls++;
    end
    inta_d = bus_o.inta_n;
    if (mon_on)
    begin
      rd_low += !bus_o.rd_n;
      wr_low += !bus_o.wr_n;
      if (bus_o.ale)
      begin
        check("addr_bit_zero", cur_a0, bus_o.muxed_addr_data[0]);
        check("lane_t1", cur_byte & ~cur_a0, bus_o.upper_lane_enable_n);
        check("mem_io_t1", cur_mem, bus_o.mem_io);
      end
      if (!bus_o.rd_n || !bus_o.wr_n)
      begin
        check("segment", {2'b00, cur_seg}, bus_o.addr_status);
        check("spare", cur_sp, bus_o.upper_lane_enable_n);
        check("mem_io", cur_mem, bus_o.mem_io);
      end
      if (!bus_o.rd_n)
      begin
        check("ad_float", 32'h0, bus_o.muxed_addr_data_oe);
      end
      if (!bus_o.wr_n && !cur_byte)
      begin
        check("wdata", cur_wd, bus_o.muxed_addr_data);
      end
    end
    if (irq_on && bus_o.ale)
    begin
      if (ale_cnt == 0)
      begin
        check("ack1_lane", 32'h2, {bus_o.upper_lane_enable_oe, bus_o.upper_lane_enable_n});
      end
      if (ale_cnt == 1)
      begin
        check("ack2_lane_oe", 32'h0, bus_o.upper_lane_enable_oe);
      end
      ale_cnt++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h5c2e_a68b;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("reset_pins", 32'h3c, {ack_o, bus_o.rd_n, bus_o.wr_n, bus_o.inta_n, bus_o.mem_io,
          bus_o.ale, bus_o.muxed_addr_data_oe});
    wb(1'b0, `REG_CTRL, 32'h0, r);
    check("ctrl_reset", `CTRL_RESET, r);
    // All four memory and I/O kinds, random lanes, segments and waits; first four with no waits
    for (i = 0; i < 24; i++)
    begin
      r = $random(seed);
      wait_n <= (i < 4) ? 4'h0 : {1'b0, r[25:23]};
      run_cycle(3'(i % 4), r[20], r[22:21], {r[19:1], r[0] & r[20]}, r[31:16] ^ r[15:0], r[26]);
    end
    // Bus release floats the strobes high and refuses new cycles
    wb(1'b1, `REG_CTRL, 32'h2, r);
    repeat (2) @(posedge clk_i);
    check("release_pins", 32'h1, {bus_o.strobe_oe, bus_o.upper_lane_enable_oe, bus_o.rd_n});
    wb(1'b1, `REG_CMD, 32'h0, r);
    wb(1'b0, `REG_STATUS, 32'h0, r);
    check("release_status", 32'h9, r & 32'h9);
    wb(1'b1, `REG_CTRL, 32'h0, r);
    wb(1'b1, `REG_STATUS, 32'h8, r);
    wb(1'b0, 8'h1c, 32'h0, r);
    check("unmapped", 32'h0, r);
    // Interrupt masked first, then taken with a wait count of 2, which adds no wait state
    irq_i <= 1'b1;
    wait_n <= 4'h2;
    repeat (5) @(posedge clk_i);
    instr_last_i <= 1'b1;
    @(posedge clk_i);
    instr_last_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    wb(1'b0, `REG_STATUS, 32'h0, r);
    check("masked_irq", 32'h0, r[1]);
    wb(1'b1, `REG_CTRL, 32'h1, r);
    irq_on = 1'b1;
    ale_cnt = 0;
    inta_falls = 0;
    instr_last_i <= 1'b1;
    @(posedge clk_i);
    instr_last_i <= 1'b0;
    poll(2, 1'b1);
    check("irq_status", {IRQ_TYPE, 2'b11}, {r[15:8], r[2:1]});
    check("ack_count", 32'h2, inta_falls);
    wb(1'b0, `REG_VECTOR, 32'h0, r);
    check("vector", {mem_word({10'h0, IRQ_TYPE, 2'b10}), mem_word({10'h0, IRQ_TYPE, 2'b00})}, r);
    irq_i <= 1'b0;
    wb(1'b1, `REG_STATUS, 32'h6, r);
    wb(1'b0, `REG_STATUS, 32'h0, r);
    check("irq_cleared", 32'h0, r & 32'h6);
    print_verdict();
  end
endmodule // cpu_local_bus_strobes_ready_irq_bench

/* File: bench/local_bus_mem_model.sv */
// Memory and I/O partner that answers local bus cycles with programmable waits
`timescale 1ns/1ps
module local_bus_mem_model
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire local_bus_pkg::bus_pins_t bus_i,
  input  wire logic [3:0]               wait_n_i,
  input  wire logic [7:0]               irq_type_i,
  output logic                          ready_o,
  output logic [15:0]                   data_o
);
  import local_bus_pkg::*;

  logic [19:0] addr_q;
  logic [3:0]  cnt_q;
  logic [15:0] last_q;
  logic        strobe;

  assign strobe = !bus_i.rd_n || !bus_i.wr_n || !bus_i.inta_n;
  // Ready built from a clocked count, so it is already synchronous
  assign ready_o = (cnt_q >= wait_n_i);

  always @(posedge clk_i)
  begin
    if (bus_i.ale)
    begin
      addr_q <= {bus_i.addr_status, bus_i.muxed_addr_data};
    end
    if (rst_i || !strobe)
    begin
      cnt_q <= 4'h0;
    end
    else if (cnt_q != 4'hf)
    begin
      cnt_q <= cnt_q + 4'h1;
    end
    last_q <= rst_i ? 16'h0000 : data_o;
  end

  // Released lines toggle every clock, so a late sample never sees old data
  always_comb
  begin
    if (!bus_i.inta_n)
    begin
      data_o = {8'h00, irq_type_i};
    end
    else if (!bus_i.rd_n)
    begin
      data_o = addr_q[15:0] ^ 16'h5a5a;
    end
    else
    begin
      data_o = ~last_q;
    end
  end
endmodule // local_bus_mem_model

/* File: verilog/irq_sampler.sv */
// Maskable interrupt synchroniser and end-of-instruction sampler
`timescale 1ns/1ps
module irq_sampler
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic maskable_irq_i,
  input  wire logic instr_last_i,
  input  wire logic if_flag_i,
  input  wire logic idle_i,
  output logic      accept_o
);
  import local_bus_pkg::*;

  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       level_q;
  logic       level_d;

  always_comb
  begin
    sync_d  = {sync_q[1:0], maskable_irq_i};
    level_d = level_q;
    if (sync_q[1] == sync_q[2])
    begin
      level_d = sync_q[2];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
    end
    else
    begin
      sync_q  <= sync_d;
      level_q <= level_d;
    end
  end

  // Level, not edge: a request dropped before the sample is lost
  assign accept_o = level_q && instr_last_i && if_flag_i && idle_i;

  ////////////////////////////////////////////////////////////////////////////
  a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    accept_o |-> if_flag_i)
    else $error("Interrupt accepted while masked");
  a_irq_at_end: assert property (@(posedge clk_i) disable iff (rst_i)
    accept_o |-> instr_last_i && level_q)
    else $error("Interrupt accepted outside instruction end");
  a_irq_sync_agree: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(level_q) |-> $past(sync_q[1]) && $past(sync_q[2]))
    else $error("Interrupt level changed without agreement");

endmodule // irq_sampler

/* File: verilog/local_bus_pkg.sv */
// Types shared by the local bus unit and its interrupt sampler
package local_bus_pkg;

  typedef enum logic [2:0] {
    KIND_MEM_RD, KIND_MEM_WR, KIND_IO_RD, KIND_IO_WR, KIND_INTA
  } cycle_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4
  } bus_state_t;

  typedef enum logic [2:0] {
    SEQ_NONE, SEQ_ACK1, SEQ_ACK2, SEQ_VEC_LO, SEQ_VEC_HI
  } irq_seq_t;

  typedef struct packed {
    logic [15:0] muxed_addr_data;
    logic        muxed_addr_data_oe;
    logic [3:0]  addr_status;
    logic        addr_status_oe;
    logic        upper_lane_enable_n;
    logic        upper_lane_enable_oe;
    logic        rd_n;
    logic        wr_n;
    logic        strobe_oe;
    logic        inta_n;
    logic        mem_io;
    logic        ale;
  } bus_pins_t;

endpackage

/* File: verilog/local_bus_regs.svh */
// Register offsets, field positions, reset values, segment code and vector step
`ifndef LOCAL_BUS_REGS_SVH
`define LOCAL_BUS_REGS_SVH

`define REG_CTRL          8'h00
`define REG_ADDR          8'h04
`define REG_WDATA         8'h08
`define REG_CMD           8'h0c
`define REG_STATUS        8'h10
`define REG_RDATA         8'h14
`define REG_VECTOR        8'h18

`define CTRL_IF_BIT       0
`define CTRL_RELEASE_BIT  1
`define CTRL_SPARE_BIT    2
`define CTRL_RESET        32'h0000_0000

`define CMD_KIND_LSB      0
`define CMD_KIND_MSB      2
`define CMD_BYTE_BIT      3
`define CMD_SEG_LSB       4
`define CMD_SEG_MSB       5

`define STAT_BUSY_BIT     0
`define STAT_IRQ_BIT      1
`define STAT_VEC_BIT      2
`define STAT_ERR_BIT      3
`define STAT_TYPE_LSB     8
`define STAT_TYPE_MSB     15

`define SEG_CODE_NONE     2'h2
`define VECTOR_STEP       20'h0_0002

`endif

/* File: verilog/local_bus_unit.sv */
// Multiplexed local bus cycle engine with Wishbone register access
//
// Overview of operation
// - Segment status bits name segment in t2-t4
// - Spare status bit shown during t2-t4
// - Upper lane enable low-active, floats in acks
// - Upper lane enable low in first ack t1
// - Lane enable and bit zero choose bytes
// - Bit zero low for lower lane byte
// - Read strobe for every memory or I/O read
// - Memory/IO line stable through whole cycle
// - Read strobe low in t2, t3, waits only
// - Read strobe waits until address/data floated
// - Read strobe floats high during bus release
// - Interrupt level sampled at instruction end
// - Accepted interrupt fetches vector from memory
// - Interrupt ignored while enable flag clear
// - Interrupt request synchronised internally
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "local_bus_regs.svh"
module local_bus_unit
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  input  wire logic [3:0]         sel_i,
  input  wire logic               we_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  output logic                    ack_o,
  input  wire logic               instr_last_i,
  input  wire logic               maskable_irq_i,
  input  wire logic               ready_i,
  input  wire logic [15:0]        muxed_addr_data_i,
  output local_bus_pkg::bus_pins_t bus_o
);
  import local_bus_pkg::*;

  logic [31:0] ctrl_q, ctrl_d, addr_reg_q, addr_reg_d, wdata_reg_q, wdata_reg_d;
  logic        ack_q, ack_d, irq_flag_q, irq_flag_d, vec_flag_q, vec_flag_d;
  logic        err_q, err_d;
  logic [31:0] rd_q, rd_d, wmask, rd_mux;
  logic        wr_ack, cmd_wr, cmd_legal, cmd_go, irq_go, idle_free, vec_set;
  cycle_kind_t cmd_kind;

  bus_state_t  state_q, state_d;
  logic        phase_q, phase_d, release_q, release_d, byte_q, byte_d;
  cycle_kind_t kind_q, kind_d;
  irq_seq_t    seq_q, seq_d;
  logic [19:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d, ip_q, ip_d, cs_q, cs_d;
  logic [1:0]  seg_q, seg_d;
  logic [7:0]  type_q, type_d;
  bus_pins_t   pins_q, pins_d;
  logic        rd_kind_d, wr_kind_d, inta_d, strobe_time;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait cycle, writes land at the ack edge
  assign wr_ack    = ack_q && cyc_i && stb_i && we_i;
  assign cmd_wr    = wr_ack && (adr_i == `REG_CMD);
  assign cmd_kind  = cycle_kind_t'(dat_i[`CMD_KIND_MSB:`CMD_KIND_LSB]);
  // Odd-address words would need two cycles; refused instead
  assign cmd_legal = (cmd_kind <= KIND_IO_WR) && (dat_i[`CMD_BYTE_BIT] || !addr_reg_q[0]);
  assign idle_free = (state_q == ST_IDLE) && !release_q;
  assign cmd_go    = cmd_wr && cmd_legal && idle_free;
  assign wmask     = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign ack_o     = ack_q;
  assign dat_o     = rd_q;
  assign bus_o     = pins_q;

  always_comb
  begin
    unique case (adr_i)
      `REG_CTRL:   rd_mux = ctrl_q;
      `REG_ADDR:   rd_mux = addr_reg_q;
      `REG_WDATA:  rd_mux = wdata_reg_q;
      `REG_STATUS: rd_mux = {16'h0000, type_q, 4'h0, err_q, vec_flag_q, irq_flag_q,
                             !idle_free};
      `REG_RDATA:  rd_mux = {16'h0000, rdata_q};
      `REG_VECTOR: rd_mux = {cs_q, ip_q};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    ack_d       = cyc_i && stb_i && !ack_q;
    rd_d        = ack_d ? rd_mux : rd_q;
    ctrl_d      = ctrl_q;
    addr_reg_d  = addr_reg_q;
    wdata_reg_d = wdata_reg_q;
    irq_flag_d  = irq_flag_q;
    vec_flag_d  = vec_flag_q;
    err_d       = err_q;
    if (wr_ack && adr_i == `REG_CTRL)
    begin
      ctrl_d = (ctrl_q & ~wmask) | (dat_i & wmask);
    end
    if (wr_ack && adr_i == `REG_ADDR)
    begin
      addr_reg_d = {12'h000, ((addr_reg_q[19:0] & ~wmask[19:0]) | (dat_i[19:0] & wmask[19:0]))};
    end
    if (wr_ack && adr_i == `REG_WDATA)
    begin
      wdata_reg_d = {16'h0000, ((wdata_reg_q[15:0] & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]))};
    end
    if (wr_ack && adr_i == `REG_STATUS && sel_i[0])
    begin
      irq_flag_d = irq_flag_q && !dat_i[`STAT_IRQ_BIT];
      vec_flag_d = vec_flag_q && !dat_i[`STAT_VEC_BIT];
      err_d      = err_q && !dat_i[`STAT_ERR_BIT];
    end
    // Hardware set wins over a same-cycle software clear
    if (irq_go)
    begin
      irq_flag_d = 1'b1;
    end
    if (vec_set)
    begin
      vec_flag_d = 1'b1;
    end
    if (cmd_wr && !cmd_go)
    begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q       <= 1'b0;
      rd_q        <= 32'h0000_0000;
      ctrl_q      <= `CTRL_RESET;
      addr_reg_q  <= 32'h0000_0000;
      wdata_reg_q <= 32'h0000_0000;
      irq_flag_q  <= 1'b0;
      vec_flag_q  <= 1'b0;
      err_q       <= 1'b0;
    end
    else
    begin
      ack_q       <= ack_d;
      rd_q        <= rd_d;
      ctrl_q      <= ctrl_d;
      addr_reg_q  <= addr_reg_d;
      wdata_reg_q <= wdata_reg_d;
      irq_flag_q  <= irq_flag_d;
      vec_flag_q  <= vec_flag_d;
      err_q       <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request path
  irq_sampler u_irq
  (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .maskable_irq_i (maskable_irq_i),
    .instr_last_i   (instr_last_i),
    .if_flag_i      (ctrl_q[`CTRL_IF_BIT]),
    .idle_i         (idle_free && !cmd_wr),
    .accept_o       (irq_go)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle engine: each bus state other than idle spans two clocks (phase 0, 1)
  always_comb
  begin
    state_d = state_q;
    phase_d = 1'b0;
    release_d = release_q;
    kind_d = kind_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    byte_d = byte_q;
    seg_d = seg_q;
    seq_d = seq_q;
    rdata_d = rdata_q;
    type_d = type_q;
    ip_d = ip_q;
    cs_d = cs_q;
    vec_set = 1'b0;
    if (state_q == ST_IDLE)
    begin
      // Bus is handed over only between cycles
      release_d = ctrl_q[`CTRL_RELEASE_BIT] && !cmd_go && !irq_go;
      if (cmd_go)
      begin
        state_d = ST_T1;
        kind_d  = cmd_kind;
        addr_d  = addr_reg_q[19:0];
        wdata_d = wdata_reg_q[15:0];
        byte_d  = dat_i[`CMD_BYTE_BIT];
        seg_d   = dat_i[`CMD_SEG_MSB:`CMD_SEG_LSB];
      end
      else if (irq_go)
      begin
        state_d = ST_T1;
        kind_d  = KIND_INTA;
        seq_d   = SEQ_ACK1;
        seg_d   = `SEG_CODE_NONE;
      end
    end
    else
    begin
      phase_d = !phase_q;
      if (phase_q)
      begin
        unique case (state_q)
          ST_T1: state_d = ST_T2;
          ST_T2: state_d = ST_T3;
          ST_T3, ST_TW:
          begin
            // Ready is used raw; the far side delivers it synchronous
            if (ready_i)
            begin
              state_d = ST_T4;
              if (seq_q == SEQ_ACK2) type_d = muxed_addr_data_i[7:0];
              else if (seq_q == SEQ_VEC_LO) ip_d = muxed_addr_data_i;
              else if (seq_q == SEQ_VEC_HI) cs_d = muxed_addr_data_i;
              else if (kind_q == KIND_MEM_RD || kind_q == KIND_IO_RD) rdata_d = muxed_addr_data_i;
            end
            else
            begin
              state_d = ST_TW;
            end
          end
          ST_T4:
          begin
            state_d = ST_T1;
            unique case (seq_q)
              SEQ_ACK1: seq_d = SEQ_ACK2;
              SEQ_ACK2:
              begin
                seq_d  = SEQ_VEC_LO;
                kind_d = KIND_MEM_RD;
                byte_d = 1'b0;
                addr_d = {10'h000, type_q, 2'h0};
              end
              SEQ_VEC_LO:
              begin
                seq_d  = SEQ_VEC_HI;
                addr_d = addr_q + `VECTOR_STEP;
              end
              SEQ_VEC_HI:
              begin
                seq_d   = SEQ_NONE;
                state_d = ST_IDLE;
                vec_set = 1'b1;
              end
              default:
              begin
                seq_d   = SEQ_NONE;
                state_d = ST_IDLE;
              end
            endcase
          end
          default: state_d = ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin values from next state, so pins line up with state_q
  always_comb
  begin
    rd_kind_d   = (kind_d == KIND_MEM_RD) || (kind_d == KIND_IO_RD);
    wr_kind_d   = (kind_d == KIND_MEM_WR) || (kind_d == KIND_IO_WR);
    inta_d      = (kind_d == KIND_INTA);
    strobe_time = (state_d == ST_T3) || (state_d == ST_TW) || (state_d == ST_T2 && phase_d);
    pins_d = pins_q;
    pins_d.ale = (state_d == ST_T1) && phase_d;
    pins_d.strobe_oe = 1'b1;
    pins_d.addr_status_oe = 1'b1;
    pins_d.upper_lane_enable_oe = 1'b1;
    pins_d.muxed_addr_data_oe = 1'b0;
    // Read strobe only after address drivers are off (phase 1 of t2)
    pins_d.rd_n   = !(rd_kind_d && strobe_time);
    pins_d.wr_n   = !(wr_kind_d && (strobe_time || state_d == ST_T2));
    pins_d.inta_n = !(inta_d && strobe_time);
    if (state_d == ST_T1 && !phase_d)
    begin
      pins_d.mem_io = (kind_d == KIND_MEM_RD) || (kind_d == KIND_MEM_WR);
    end
    if (state_d == ST_T1)
    begin
      pins_d.muxed_addr_data    = addr_d[15:0];
      pins_d.muxed_addr_data_oe = !inta_d;
      pins_d.addr_status        = (kind_d == KIND_IO_RD || kind_d == KIND_IO_WR) ?
                                  4'h0 : addr_d[19:16];
      pins_d.upper_lane_enable_n  = !(!byte_d || addr_d[0]);
      pins_d.upper_lane_enable_oe = !inta_d || (seq_d == SEQ_ACK1);
      if (inta_d)
      begin
        pins_d.upper_lane_enable_n = 1'b0;
      end
    end
    else if (state_d != ST_IDLE)
    begin
      pins_d.addr_status = {1'b0, ctrl_q[`CTRL_IF_BIT], seg_d};
      pins_d.upper_lane_enable_n  = ctrl_q[`CTRL_SPARE_BIT];
      pins_d.upper_lane_enable_oe = !inta_d;
      if (wr_kind_d)
      begin
        pins_d.muxed_addr_data    = wdata_d;
        pins_d.muxed_addr_data_oe = 1'b1;
      end
    end
    if (release_d)
    begin
      pins_d.addr_status_oe = 1'b0;
      pins_d.upper_lane_enable_oe = 1'b0;
      pins_d.strobe_oe = 1'b0;
      pins_d.rd_n = 1'b1;
      pins_d.wr_n = 1'b1;
      pins_d.mem_io = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      phase_q <= 1'b0;
      release_q <= 1'b0;
      kind_q <= KIND_MEM_RD;
      seq_q <= SEQ_NONE;
      addr_q <= 20'h0_0000;
      wdata_q <= 16'h0000;
      byte_q <= 1'b0;
      seg_q <= 2'h0;
      rdata_q <= 16'h0000;
      type_q <= 8'h00;
      ip_q <= 16'h0000;
      cs_q <= 16'h0000;
      pins_q <= {16'h0000, 1'b0, 4'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    end
    else
    begin
      state_q <= state_d;
      phase_q <= phase_d;
      release_q <= release_d;
      kind_q <= kind_d;
      seq_q <= seq_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      byte_q <= byte_d;
      seg_q <= seg_d;
      rdata_q <= rdata_d;
      type_q <= type_d;
      ip_q <= ip_d;
      cs_q <= cs_d;
      pins_q <= pins_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_seg_status_shown: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q inside {ST_T2, ST_T3, ST_TW, ST_T4} |-> pins_q.addr_status[1:0] == seg_q)
    else $error("Segment status wrong in t2-t4");
  a_spare_status_shown: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q inside {ST_T2, ST_T3, ST_T4} && kind_q != KIND_INTA |->
      pins_q.upper_lane_enable_oe &&
      pins_q.upper_lane_enable_n == $past(ctrl_q[`CTRL_SPARE_BIT]))
    else $error("Spare status bit not shown");
  a_lane_float_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (kind_q == KIND_INTA && state_q != ST_T1 && state_q != ST_IDLE) || release_q |->
      !pins_q.upper_lane_enable_oe)
    else $error("Upper lane enable driven in ack or release");
  a_lane_first_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_T1 && seq_q == SEQ_ACK1 |->
      pins_q.upper_lane_enable_oe && !pins_q.upper_lane_enable_n)
    else $error("Upper lane enable not low in first ack t1");
  a_lane_select_code: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_T1 && kind_q != KIND_INTA |->
      {pins_q.upper_lane_enable_n, pins_q.muxed_addr_data[0]} ==
        (byte_q ? {!addr_q[0], addr_q[0]} : 2'h0))
    else $error("Byte lane code wrong");
  a_rd_every_read: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_T2 && phase_q && kind_q inside {KIND_MEM_RD, KIND_IO_RD} |=>
      !pins_q.rd_n [*2])
    else $error("Read strobe missing in read");
  a_mem_io_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q != ST_IDLE && !(state_q == ST_T1 && !phase_q) |-> $stable(pins_q.mem_io))
    else $error("Memory/IO line changed mid cycle");
  a_rd_low_window: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q inside {ST_IDLE, ST_T1, ST_T4} || (state_q == ST_T2 && !phase_q) |-> pins_q.rd_n)
    else $error("Read strobe low outside t2-tw");
  a_rd_after_float: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(pins_q.rd_n) |-> !pins_q.muxed_addr_data_oe && $past(!pins_q.muxed_addr_data_oe))
    else $error("Read strobe fell before bus floated");
  a_rd_release_high: assert property (@(posedge clk_i) disable iff (rst_i)
    release_q |-> !pins_q.strobe_oe && pins_q.rd_n)
    else $error("Read strobe not released high");
  a_wait_on_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q inside {ST_T3, ST_TW} && phase_q && !ready_i |=>
      state_q == ST_TW && (kind_q != KIND_MEM_RD || !pins_q.rd_n))
    else $error("No wait state on ready low");
  a_vector_address: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_T1 && seq_q == SEQ_VEC_LO |->
      pins_q.muxed_addr_data == {6'h00, type_q, 2'h0} && pins_q.mem_io)
    else $error("Vector fetch address wrong");
  a_cycle_end_clean: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_T4 && phase_q |=> state_q inside {ST_T1, ST_IDLE} &&
      pins_q.rd_n && pins_q.wr_n && pins_q.inta_n ##1 state_q != ST_T4)
    else $error("Bus cycle did not end cleanly");

endmodule // local_bus_unit
